// ### capture_pkg.sv
package capture_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] control_addr = 4'h0;
   localparam logic [3:0] buffer_addr = 4'h4;
   localparam logic [3:0] power_addr = 4'h8;

   // ----------------------------------------------------------------
   // control field positions and reset values
   // ----------------------------------------------------------------
   localparam int idle_stop_bit = 13;
   localparam int timebase_bit = 7;
   localparam int per_irq_lsb = 5;
   localparam int overflow_bit = 4;
   localparam int not_empty_bit = 3;
   localparam int mode_lsb = 0;
   localparam logic [15:0] control_reset = 16'h0000;
   localparam logic [15:0] control_write_mask = 16'h20e7;
   localparam logic [1:0] power_reset = 2'h0;

   // ----------------------------------------------------------------
   // mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] mode_off = 3'h0;
   localparam logic [2:0] mode_every_edge = 3'h1;
   localparam logic [2:0] mode_fall = 3'h2;
   localparam logic [2:0] mode_rise = 3'h3;
   localparam logic [2:0] mode_rise4 = 3'h4;
   localparam logic [2:0] mode_rise16 = 3'h5;
   localparam logic [2:0] mode_reserved = 3'h6;
   localparam logic [2:0] mode_wake = 3'h7;

   localparam logic [3:0] prescale_4_last = 4'h3;
   localparam logic [3:0] prescale_16_last = 4'hf;

   localparam logic [1:0] axi_okay = 2'h0;
   localparam logic [1:0] axi_slverr = 2'h2;

   typedef struct packed {
      logic idle_stop_select;
      logic timebase_select;
      logic [1:0] captures_per_irq;
      logic [2:0] capture_mode_select;
   } control_t;

   typedef struct packed {
      logic sleep_mode;
      logic idle_mode;
   } power_t;

endpackage

// ### capture_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module capture_fifo
   import capture_pkg::*;
#(
   parameter int width = 16,
   parameter int depth = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clear,
   input wire logic push,
   input wire logic [width-1:0] push_data,
   input wire logic pop,
   output logic [width-1:0] head_data,
   output logic not_empty,
   output logic full
);

   localparam int aw = $clog2(depth);

   logic [width-1:0] mem [depth];
   logic [aw-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [aw:0] count, next_count;
   logic do_push, do_pop;

   // ----------------------------------------------------------------
   // pointers
   // ----------------------------------------------------------------
   always_comb begin
      do_push = push && (count != (aw+1)'(depth));
      do_pop = pop && (count != '0);
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (clear) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end else begin
         if (do_push) next_wr_ptr = (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
         if (do_pop) next_rd_ptr = (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
         next_count = count + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // storage has no reset; head comes out of a register
   always_ff @(posedge clk_sys) begin
      if (do_push && !clear) mem[wr_ptr] <= push_data;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) head_data <= '0;
      else head_data <= mem[next_rd_ptr];
   end

   assign not_empty = (count != '0);
   assign full = (count == (aw+1)'(depth));

endmodule

`default_nettype wire

// ### input_capture_channel.sv
// Notes on behaviour
// - timebase bit 1 captures timer b count, 0 captures timer c count
// - two-bit field sets interrupt after 1, 2, 3 or 4 captures
// - read-only overflow flag, set on overflow, cleared by hardware, resets 0
// - read-only not-empty flag is 1 while unread captures remain
// - mode 111 is a wake interrupt pin in sleep or idle, no capture
// - mode 111 uses rising edges only and ignores other control bits
// - mode 100 captures on every 4th rising edge
// - mode 011 captures on every rising edge
// - mode 001 captures on every rising and falling edge
// - in mode 001 the per-interrupt field is ignored
// - mode 000 turns the channel off: no capture, no interrupt
// - writable control bits reset to 0, unimplemented bits read 0
`timescale 1ns/1ps
`default_nettype none

module input_capture_channel
   import capture_pkg::*;
#(
   parameter int timer_width = 16,
   parameter int fifo_depth = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic capture_pin,
   input wire logic [timer_width-1:0] timer_b_count,
   input wire logic [timer_width-1:0] timer_c_count,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic capture_irq
);

   // ----------------------------------------------------------------
   // pin synchroniser and edge detection
   // ----------------------------------------------------------------
   logic pin_meta, pin_sync, pin_prev;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= capture_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   logic rise, fall;
   assign rise = pin_sync && !pin_prev;
   assign fall = !pin_sync && pin_prev;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   control_t ctrl, next_ctrl;
   power_t power, next_power;
   logic overflow, next_overflow;
   logic [3:0] prescale, next_prescale;
   logic [1:0] irq_count, next_irq_count;
   logic next_irq;
   logic mode_written;

   logic fifo_push, fifo_pop, fifo_full, fifo_not_empty;
   logic [timer_width-1:0] fifo_head, capture_value;

   // axi state
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [3:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic do_write, do_read;

   function automatic logic addr_known(input logic [3:0] a);
      return (a == control_addr) || (a == buffer_addr) || (a == power_addr);
   endfunction

   function automatic logic [15:0] control_word(input control_t c, input logic ov,
                                                input logic ne);
      logic [15:0] w;
      w = 16'h0000;
      w[idle_stop_bit] = c.idle_stop_select;
      w[timebase_bit] = c.timebase_select;
      w[per_irq_lsb +: 2] = c.captures_per_irq;
      w[overflow_bit] = ov;
      w[not_empty_bit] = ne;
      w[mode_lsb +: 3] = c.capture_mode_select;
      return w;
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = addr_known(aw_addr) ? axi_okay : axi_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      do_read = s_axi_arvalid && s_axi_arready;
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rresp = axi_okay;
         next_rdata = 32'h0000_0000;
         case (s_axi_araddr)
            control_addr: next_rdata[15:0] = control_word(ctrl, overflow, fifo_not_empty);
            buffer_addr: next_rdata[timer_width-1:0] = fifo_head;
            power_addr: next_rdata[1:0] = power;
            default: next_rresp = axi_slverr;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // a buffer read pops the oldest entry
   assign fifo_pop = do_read && (s_axi_araddr == buffer_addr);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_arready <= next_arready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // control registers and capture engine
   // ----------------------------------------------------------------
   logic [15:0] merged;
   logic halted, mode_on, edge_hit, capture_event, irq_now;

   always_comb begin
      next_ctrl = ctrl;
      next_power = power;
      merged = control_word(ctrl, 1'b0, 1'b0);
      mode_written = 1'b0;
      if (do_write && aw_addr == control_addr) begin
         if (w_strb[0]) merged[7:0] = w_data[7:0];
         if (w_strb[1]) merged[15:8] = w_data[15:8];
         merged = merged & control_write_mask;
         next_ctrl.idle_stop_select = merged[idle_stop_bit];
         next_ctrl.timebase_select = merged[timebase_bit];
         next_ctrl.captures_per_irq = merged[per_irq_lsb +: 2];
         next_ctrl.capture_mode_select = merged[mode_lsb +: 3];
         mode_written = w_strb[0];
      end
      if (do_write && aw_addr == power_addr && w_strb[0]) begin
         next_power = w_data[1:0];
      end
   end

   always_comb begin
      halted = ctrl.idle_stop_select && power.idle_mode;
      mode_on = 1'b0;
      edge_hit = 1'b0;
      next_prescale = prescale;
      case (ctrl.capture_mode_select)
         mode_every_edge: edge_hit = rise || fall;
         mode_fall: edge_hit = fall;
         mode_rise: edge_hit = rise;
         mode_rise4: begin
            if (rise && !halted) begin
               next_prescale = (prescale == prescale_4_last) ? 4'h0 : prescale + 4'h1;
            end
            edge_hit = rise && (prescale == prescale_4_last);
         end
         mode_rise16: begin
            if (rise && !halted) next_prescale = prescale + 4'h1;
            edge_hit = rise && (prescale == prescale_16_last);
         end
         default: edge_hit = 1'b0; // off, reserved and wake modes
      endcase
      mode_on = edge_hit;
      capture_event = mode_on && !halted;
      if (mode_written) next_prescale = 4'h0;
      capture_value = ctrl.timebase_select ? timer_b_count : timer_c_count;
      fifo_push = capture_event && !fifo_full;
      next_overflow = overflow;
      if (capture_event && fifo_full) next_overflow = 1'b1;
      else if (!fifo_not_empty) next_overflow = 1'b0;
      next_irq_count = irq_count;
      irq_now = 1'b0;
      if (ctrl.capture_mode_select == mode_wake) begin
         irq_now = rise && (power.sleep_mode || power.idle_mode);
      end else if (capture_event) begin
         if (ctrl.capture_mode_select == mode_every_edge) begin
            irq_now = 1'b1;
         end else if (irq_count == ctrl.captures_per_irq) begin
            irq_now = 1'b1;
            next_irq_count = 2'h0;
         end else begin
            next_irq_count = irq_count + 2'h1;
         end
      end
      if (mode_written || ctrl.capture_mode_select == mode_off) begin
         next_irq_count = 2'h0;
      end
      next_irq = irq_now;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl <= control_t'(7'h00);
         power <= power_reset;
         overflow <= 1'b0;
         prescale <= 4'h0;
         irq_count <= 2'h0;
         capture_irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         power <= next_power;
         overflow <= next_overflow;
         prescale <= next_prescale;
         irq_count <= next_irq_count;
         capture_irq <= next_irq;
      end
   end

   capture_fifo #(
      .width(timer_width),
      .depth(fifo_depth)
   ) u_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clear(1'b0),
      .push(fifo_push),
      .push_data(capture_value),
      .pop(fifo_pop),
      .head_data(fifo_head),
      .not_empty(fifo_not_empty),
      .full(fifo_full)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   idle_halt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (halted && !fifo_not_empty) |=> !fifo_not_empty) else $error("capture while halted");
   overflow_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (capture_event && fifo_full) |=> overflow) else $error("overflow not set");
   not_empty_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      fifo_push |=> fifo_not_empty) else $error("buffer flag stays low");
   off_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_off) |=> !capture_irq || $past(mode_written))
      else $error("interrupt while off");
   wake_nocap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_wake) |-> !fifo_push) else $error("capture in wake mode");
   rise_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_rise && rise && !halted && !fifo_full) |-> fifo_push)
      else $error("rising edge missed");
   fall_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_fall && rise) |-> !fifo_push)
      else $error("rising edge captured in falling mode");
   each_edge_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_every_edge && capture_event) |=> capture_irq)
      else $error("every-edge interrupt missing");
   wake_fall_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_wake && fall) |=> !capture_irq)
      else $error("falling edge woke the channel");
   off_nocap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_off) |-> !fifo_push) else $error("capture while off");
   quarter_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctrl.capture_mode_select == mode_rise4) |-> (prescale <= prescale_4_last))
      else $error("prescaler passed fourth edge");
   irq_limit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      irq_count <= ctrl.captures_per_irq) else $error("interrupt counter overran");
   count_restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      mode_written |=> (irq_count == 2'h0)) else $error("interrupt counter kept on mode write");

endmodule

`default_nettype wire

// ### capture_source.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// far-side signal source driving the capture pin
// ----------------------------------------------------------------
module capture_source (
   input wire logic clk_sys,
   output logic capture_pin
);
   initial capture_pin = 1'b0;

   // gap sets how long the level stands, so one model serves fast and slow sources
   task automatic toggle(input int gap);
      @(posedge clk_sys);
      capture_pin <= ~capture_pin;
      repeat (gap) @(posedge clk_sys);
   endtask
endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
   import capture_pkg::*;
;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic capture_pin;
   logic [15:0] timer_b_count = 16'h0000;
   logic [15:0] timer_c_count = 16'h0000;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int irq_n = 0;
   int seq = 0;
   logic [15:0] got [$];

   always #5 clk_sys = ~clk_sys;

   input_capture_channel dut (.clk_sys(clk_sys), .resetn(resetn), .capture_pin(capture_pin),
      .timer_b_count(timer_b_count), .timer_c_count(timer_c_count),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .capture_irq(capture_irq));

   capture_source src (.clk_sys(clk_sys), .capture_pin(capture_pin));

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // irq pulses last one cycle, so they are counted rather than polled
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (capture_irq === 1'b1) irq_n <= irq_n + 1;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // waits have no local limit: only the cycle ceiling ends a hung transfer
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'h3;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      resp = s_axi_rresp;
   endtask

   // ----------------------------------------------------------------
   // capture helpers
   // ----------------------------------------------------------------
   // timers change a cycle before the pin so the captured count is settled
   task automatic edge_go(input int gap);
      @(posedge clk_sys);
      timer_b_count <= 16'hb000 + 16'(seq);
      timer_c_count <= 16'hc000 + 16'(seq);
      seq++;
      src.toggle(gap);
   endtask

   task automatic drain(output int caps);
      logic [31:0] d;
      caps = 0;
      got.delete();
      repeat (6) begin
         rd(control_addr, d, rs);
         if (d[not_empty_bit] === 1'b1) begin
            rd(buffer_addr, d, rs);
            got.push_back(d[15:0]);
            caps++;
         end
      end
   endtask

   task automatic trial(input logic [15:0] ctrl, input logic [1:0] pwr, input int tog,
                        input int gap, input int irqs, input int caps, input logic ov);
      int base;
      int n;
      logic [31:0] d;
      wr(power_addr, {30'h0, pwr}, rs);
      wr(control_addr, {16'h0, ctrl}, rs);
      base = irq_n;
      repeat (tog) edge_go(gap);
      repeat (8) @(posedge clk_sys);
      chk("irq count", 32'(irq_n - base), 32'(irqs));
      rd(control_addr, d, rs);
      chk("flags", {30'h0, d[4:3]}, {30'h0, ov, caps != 0});
      drain(n);
      chk("captures", 32'(n), 32'(caps));
      rd(control_addr, d, rs);
      chk("control after drain", d, {16'h0, ctrl});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic regs_check();
      logic [31:0] d;
      rd(control_addr, d, rs);
      chk("control reset", d, 32'h0);
      wr(control_addr, 32'hffffffff, rs);
      rd(control_addr, d, rs);
      chk("control mask", d, {16'h0, control_write_mask});
      rd(4'hc, d, rs);
      chk("unmapped read resp", {30'h0, rs}, {30'h0, axi_slverr});
      chk("unmapped read data", d, 32'h0);
      wr(4'hc, 32'h1, rs);
      chk("unmapped write resp", {30'h0, rs}, {30'h0, axi_slverr});
      wr(control_addr, 32'h0, rs);
      chk("write resp", {30'h0, rs}, {30'h0, axi_okay});
   endtask

   task automatic timebase_check();
      int s0;
      s0 = seq;
      trial(16'h0083, 2'h0, 4, 6, 2, 2, 1'b0);
      chk("timer b first", {16'h0, got[0]}, {16'h0, 16'hb000 + 16'(s0)});
      chk("timer b second", {16'h0, got[1]}, {16'h0, 16'hb000 + 16'(s0 + 2)});
      s0 = seq;
      trial(16'h0003, 2'h0, 4, 6, 2, 2, 1'b0);
      chk("timer c first", {16'h0, got[0]}, {16'h0, 16'hc000 + 16'(s0)});
   endtask

   task automatic modes_check();
      trial(16'h0061, 2'h0, 4, 2, 4, 4, 1'b0);
      trial(16'h0002, 2'h0, 4, 6, 2, 2, 1'b0);
      trial(16'h0004, 2'h0, 16, 4, 2, 2, 1'b0);
      trial(16'h0005, 2'h0, 32, 4, 1, 1, 1'b0);
      trial(16'h0000, 2'h0, 4, 6, 0, 0, 1'b0);
      trial(16'h0006, 2'h0, 4, 6, 0, 0, 1'b0);
   endtask

   task automatic irq_check();
      int s0;
      trial(16'h0023, 2'h0, 6, 6, 1, 3, 1'b0);
      trial(16'h0043, 2'h0, 6, 20, 1, 3, 1'b0);
      s0 = seq;
      trial(16'h0063, 2'h0, 10, 6, 1, 4, 1'b1);
      chk("oldest kept", {16'h0, got[3]}, {16'h0, 16'hc000 + 16'(s0 + 6)});
      wr(control_addr, 32'h0023, rs);
      edge_go(6);
      edge_go(6);
      trial(16'h0023, 2'h0, 2, 6, 0, 2, 1'b0);
   endtask

   task automatic power_check();
      trial(16'h2003, 2'h1, 4, 6, 0, 0, 1'b0);
      trial(16'h0003, 2'h1, 4, 6, 2, 2, 1'b0);
      trial(16'h2067, 2'h1, 4, 6, 2, 0, 1'b0);
      trial(16'h0007, 2'h2, 2, 6, 1, 0, 1'b0);
      trial(16'h0007, 2'h0, 2, 6, 0, 0, 1'b0);
   endtask

   // a mid-run reset must drop both flags even with a full, overflowed queue
   task automatic reset_check();
      logic [31:0] d;
      wr(control_addr, 32'h0003, rs);
      repeat (10) edge_go(2);
      repeat (8) @(posedge clk_sys);
      rd(control_addr, d, rs);
      chk("flags before reset", {30'h0, d[4:3]}, 32'h3);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(control_addr, d, rs);
      chk("control after reset", d, 32'h0);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      regs_check();
      timebase_check();
      modes_check();
      irq_check();
      power_check();
      reset_check();
      conclude();
   end
endmodule

`default_nettype wire
